/* File: design/fbs_pkg.sv */
// constants of the flagged buffer: register map, field positions, reset values
// assumes a 32-bit register port with byte addresses on word boundaries
package fbs_pkg;
   localparam int unsigned TOTAL_BITS = 16384;
   localparam int unsigned REG_AW = 8;
   localparam int unsigned REG_DW = 32;
   localparam int unsigned THR_W = 15;
   localparam int unsigned NET_N = 4;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FULL_THR = 8'h04;
   localparam logic [7:0] ADDR_AFULL_THR = 8'h08;
   localparam logic [7:0] ADDR_AEMPTY_THR = 8'h0c;
   localparam logic [7:0] ADDR_CMD = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_INT_STAT = 8'h18;
   localparam logic [7:0] ADDR_INT_MASK = 8'h1c;

   // control field positions
   localparam int unsigned CTRL_WCLK_SEL = 0;
   localparam int unsigned CTRL_WCLK_INV = 3;
   localparam int unsigned CTRL_WCE_SEL = 4;
   localparam int unsigned CTRL_WCE_INV = 6;
   localparam int unsigned CTRL_RCLK_SEL = 7;
   localparam int unsigned CTRL_RCLK_INV = 10;
   localparam int unsigned CTRL_RCE_SEL = 11;
   localparam int unsigned CTRL_RCE_INV = 13;
   localparam int unsigned CTRL_SHOW_AHEAD = 14;
   localparam int unsigned CTRL_CLEAR_INV = 15;
   localparam int unsigned CTRL_W = 16;
   localparam logic [15:0] CTRL_RST = 16'h0000;

   // command and status field positions
   localparam int unsigned CMD_RD_REWIND = 0;
   localparam int unsigned ST_FULL = 0;
   localparam int unsigned ST_AFULL = 1;
   localparam int unsigned ST_EMPTY = 2;
   localparam int unsigned ST_AEMPTY = 3;
   localparam int unsigned ST_WCOUNT = 16;

   // interrupt event bits
   localparam int unsigned EV_FULL = 0;
   localparam int unsigned EV_AFULL = 1;
   localparam int unsigned EV_EMPTY = 2;
   localparam int unsigned EV_AEMPTY = 3;
   localparam int unsigned EV_OVERFLOW = 4;
   localparam int unsigned EV_UNDERFLOW = 5;
   localparam int unsigned EV_N = 6;
   localparam logic [5:0] INT_RST = 6'h00;

   // threshold reset values
   localparam int unsigned AFULL_MARGIN = 4;
   localparam logic [14:0] AEMPTY_THR_RST = 15'h0004;

   // clock source and enable source codes
   typedef enum logic [2:0] {
      FBS_CLK_PIN = 3'h0,
      FBS_CLK_NET0 = 3'h1,
      FBS_CLK_NET1 = 3'h2,
      FBS_CLK_NET2 = 3'h3,
      FBS_CLK_NET3 = 3'h4
   } fbs_clk_src_t;
   typedef enum logic [1:0] {
      FBS_CE_PIN = 2'h0,
      FBS_CE_NET1 = 2'h1,
      FBS_CE_NET2 = 2'h2
   } fbs_ce_src_t;
endpackage

/* File: design/fbs_edge_sel.sv */
// picks one side's clock source and enable source, finds the active edge
// assumes all sources are synchronous levels sampled on clk
`timescale 1ns/1ns
module fbs_edge_sel
(
   input wire logic clk, // system clock
   input wire logic rst, // async reset, high
   input wire logic pin_clk, // dedicated side clock pin
   input wire logic [3:0] nets, // global clock nets
   input wire logic pin_en, // side enable pin
   input wire logic [2:0] clk_sel, // clock source code
   input wire logic clk_inv, // invert clock source
   input wire logic [1:0] ce_sel, // enable source code
   input wire logic ce_inv, // invert enable source
   output logic edge_o, // active edge of chosen clock
   output logic tick_o // active edge with enable true
);
   logic lvl;
   logic ce;
   logic prev_r;
   logic prev_nxt;

   // source muxes with optional inversion
   always_comb
   begin
      case (clk_sel)
         fbs_pkg::FBS_CLK_NET0: lvl = nets[0];
         fbs_pkg::FBS_CLK_NET1: lvl = nets[1];
         fbs_pkg::FBS_CLK_NET2: lvl = nets[2];
         fbs_pkg::FBS_CLK_NET3: lvl = nets[3];
         default: lvl = pin_clk;
      endcase
      lvl = lvl ^ clk_inv;
      case (ce_sel)
         fbs_pkg::FBS_CE_NET1: ce = nets[1];
         fbs_pkg::FBS_CE_NET2: ce = nets[2];
         default: ce = pin_en;
      endcase
      ce = ce ^ ce_inv;
      prev_nxt = lvl;
   end

   // previous level; reset high so no false edge after release
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         prev_r <= 1'b1;
      else
         prev_r <= prev_nxt;
   end

   assign edge_o = lvl & ~prev_r;
   assign tick_o = lvl & ~prev_r & ce;
endmodule

/* File: design/fbs_ptr_sync.sv */
// two-stage carrier of a gray-coded pointer into the opposite side
// assumes the pointer changes by at most one step per cycle
`timescale 1ns/1ns
module fbs_ptr_sync #(
   parameter int unsigned W = 10
)
(
   input wire logic clk, // system clock
   input wire logic rst, // async reset, high
   input wire logic [W-1:0] gray_in, // gray pointer of source side
   output logic [W-1:0] bin_out // binary pointer after crossing
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s1_nxt;
   logic [W-1:0] s2_nxt;

   // next values of both stages
   always_comb
   begin
      s1_nxt = gray_in;
      s2_nxt = s1_r;
   end

   // stage registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1_r <= '0;
         s2_r <= '0;
      end
      else
      begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
      end
   end

   // gray to binary from second stage only
   always_comb
   begin
      bin_out[W-1] = s2_r[W-1];
      for (int i = W - 2; i >= 0; i--)
         bin_out[i] = bin_out[i+1] ^ s2_r[i];
   end
endmodule

/* File: design/fbs_fifo.sv */
// flagged buffer with selectable side clocks, thresholds and read rewind
// assumes synchronous pins on clk and a one-cycle register port
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
module fbs_fifo #(
   parameter int unsigned DATA_W = 32
)
(
   input wire logic clk, // system clock
   input wire logic rst, // async reset, high
   input wire logic wr_clk_pin, // dedicated fill clock
   input wire logic rd_clk_pin, // dedicated drain clock
   input wire logic [3:0] global_clock_nets, // four global nets
   input wire logic input_side_enable, // write enable
   input wire logic output_side_enable, // read enable
   input wire logic [DATA_W-1:0] wr_data, // word to push
   output logic [DATA_W-1:0] rd_data, // popped word, registered
   output logic full, // full flag, registered
   output logic almost_full, // almost full flag, registered
   output logic empty, // empty flag, registered
   output logic almost_empty, // almost empty flag, registered
   input wire logic local_clear, // flag clear from global_routing_pool
   input wire logic [7:0] reg_addr, // register byte address
   input wire logic [31:0] reg_wdata, // register write data
   input wire logic reg_wr, // register write strobe
   input wire logic reg_rd, // register read strobe
   output logic [31:0] reg_rdata, // read data, cycle after strobe
   output logic irq // level interrupt
);
   localparam int unsigned DEPTH = fbs_pkg::TOTAL_BITS / DATA_W;
   localparam int unsigned AW = $clog2(DEPTH);
   localparam int unsigned PW = AW + 1;
   localparam int unsigned TW = fbs_pkg::THR_W;

   // refuse widths the array cannot take
   if (DATA_W != 1 && DATA_W != 2 && DATA_W != 4 && DATA_W != 8 && DATA_W != 16
       && DATA_W != 32)
   begin : g_width_check
      $error("fbs_fifo: DATA_W must be 1, 2, 4, 8, 16 or 32");
   end

   logic [DATA_W-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
   logic [PW-1:0] rd_ptr_w, wr_ptr_rs;
   logic [DATA_W-1:0] rd_data_r, rd_data_nxt;
   logic full_r, full_nxt, afull_r, afull_nxt;
   logic empty_r, empty_nxt, aempty_r, aempty_nxt;
   logic [fbs_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
   logic [TW-1:0] full_thr_r, full_thr_nxt, afull_thr_r, afull_thr_nxt;
   logic [TW-1:0] aempty_thr_r, aempty_thr_nxt;
   logic [fbs_pkg::EV_N-1:0] int_stat_r, int_stat_nxt, int_mask_r, int_mask_nxt;
   logic [fbs_pkg::EV_N-1:0] ev;
   logic [31:0] reg_rdata_r, reg_rdata_nxt;
   logic w_tick, r_tick;
   logic wr_ok, rd_ok, rewind, clr;
   logic [PW-1:0] wcount, wcount_nxt, rcount, rcount_nxt;
   logic [TW-1:0] wc_ext, wcn_ext, rcn_ext;

   // write side clock and enable choice
   fbs_edge_sel u_wsel (
      .clk(clk),
      .rst(rst),
      .pin_clk(wr_clk_pin),
      .nets(global_clock_nets),
      .pin_en(input_side_enable),
      .clk_sel(ctrl_r[fbs_pkg::CTRL_WCLK_SEL +: 3]),
      .clk_inv(ctrl_r[fbs_pkg::CTRL_WCLK_INV]),
      .ce_sel(ctrl_r[fbs_pkg::CTRL_WCE_SEL +: 2]),
      .ce_inv(ctrl_r[fbs_pkg::CTRL_WCE_INV]),
      .edge_o(),
      .tick_o(w_tick)
   );

   // read side clock and enable choice
   fbs_edge_sel u_rsel (
      .clk(clk),
      .rst(rst),
      .pin_clk(rd_clk_pin),
      .nets(global_clock_nets),
      .pin_en(output_side_enable),
      .clk_sel(ctrl_r[fbs_pkg::CTRL_RCLK_SEL +: 3]),
      .clk_inv(ctrl_r[fbs_pkg::CTRL_RCLK_INV]),
      .ce_sel(ctrl_r[fbs_pkg::CTRL_RCE_SEL +: 2]),
      .ce_inv(ctrl_r[fbs_pkg::CTRL_RCE_INV]),
      .edge_o(),
      .tick_o(r_tick)
   );

   // read pointer carried to the write side
   fbs_ptr_sync #(.W(PW)) u_rd_to_wr (
      .clk(clk),
      .rst(rst),
      .gray_in(rd_ptr_r ^ (rd_ptr_r >> 1)),
      .bin_out(rd_ptr_w)
   );

   // write pointer carried to the read side
   fbs_ptr_sync #(.W(PW)) u_wr_to_rd (
      .clk(clk),
      .rst(rst),
      .gray_in(wr_ptr_r ^ (wr_ptr_r >> 1)),
      .bin_out(wr_ptr_rs)
   );

   assign clr = local_clear ^ ctrl_r[fbs_pkg::CTRL_CLEAR_INV];
   assign rewind = reg_wr && reg_addr == fbs_pkg::ADDR_CMD
                   && reg_wdata[fbs_pkg::CMD_RD_REWIND];

   // pointers, occupancy and acceptance
   always_comb
   begin
      wcount = wr_ptr_r - rd_ptr_w;
      rcount = wr_ptr_rs - rd_ptr_r;
      wc_ext = TW'(wcount);
      wr_ok = w_tick && wc_ext < full_thr_r && wcount < PW'(DEPTH);
      rd_ok = r_tick && rcount != '0;
      wr_ptr_nxt = wr_ok ? wr_ptr_r + PW'(1) : wr_ptr_r;
      if (rewind)
         rd_ptr_nxt = '0;
      else if (rd_ok)
         rd_ptr_nxt = rd_ptr_r + PW'(1);
      else
         rd_ptr_nxt = rd_ptr_r;
      wcount_nxt = wr_ptr_nxt - rd_ptr_w;
      rcount_nxt = wr_ptr_rs - rd_ptr_nxt;
      wcn_ext = TW'(wcount_nxt);
      rcn_ext = TW'(rcount_nxt);
   end

   // pointer registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end
      else
      begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
      end
   end

   // storage written on the write side tick
   always_ff @(posedge clk)
   begin
      if (wr_ok)
         mem[wr_ptr_r[AW-1:0]] <= wr_data;
   end

   // read data: on read, or every cycle ahead of it in show-ahead
   always_comb
   begin
      rd_data_nxt = rd_data_r;
      if (ctrl_r[fbs_pkg::CTRL_SHOW_AHEAD])
         rd_data_nxt = mem[rd_ptr_nxt[AW-1:0]];
      else if (rd_ok)
         rd_data_nxt = mem[rd_ptr_r[AW-1:0]];
   end

   // read data register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rd_data_r <= '0;
      else
         rd_data_r <= rd_data_nxt;
   end

   // flags: write pair on write tick, read pair on read tick or rewind
   always_comb
   begin
      full_nxt = full_r;
      afull_nxt = afull_r;
      empty_nxt = empty_r;
      aempty_nxt = aempty_r;
      if (clr)
      begin
         full_nxt = 1'b0;
         afull_nxt = 1'b0;
         empty_nxt = 1'b1;
         aempty_nxt = 1'b1;
      end
      else
      begin
         if (w_tick)
         begin
            full_nxt = wcn_ext >= full_thr_r;
            afull_nxt = wcn_ext >= afull_thr_r;
         end
         if (r_tick || rewind)
         begin
            empty_nxt = rcn_ext == '0;
            aempty_nxt = rcn_ext <= aempty_thr_r;
         end
      end
   end

   // flag registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         full_r <= 1'b0;
         afull_r <= 1'b0;
         empty_r <= 1'b1;
         aempty_r <= 1'b1;
      end
      else
      begin
         full_r <= full_nxt;
         afull_r <= afull_nxt;
         empty_r <= empty_nxt;
         aempty_r <= aempty_nxt;
      end
   end

   // events: flag rises and refused accesses
   always_comb
   begin
      ev = '0;
      ev[fbs_pkg::EV_FULL] = full_nxt & ~full_r;
      ev[fbs_pkg::EV_AFULL] = afull_nxt & ~afull_r;
      ev[fbs_pkg::EV_EMPTY] = empty_nxt & ~empty_r;
      ev[fbs_pkg::EV_AEMPTY] = aempty_nxt & ~aempty_r;
      ev[fbs_pkg::EV_OVERFLOW] = w_tick & ~wr_ok;
      ev[fbs_pkg::EV_UNDERFLOW] = r_tick & ~rd_ok;
   end

   // register writes; a set wins over a clear
   always_comb
   begin
      ctrl_nxt = ctrl_r;
      full_thr_nxt = full_thr_r;
      afull_thr_nxt = afull_thr_r;
      aempty_thr_nxt = aempty_thr_r;
      int_mask_nxt = int_mask_r;
      int_stat_nxt = int_stat_r;
      if (reg_wr)
      begin
         if (reg_addr == fbs_pkg::ADDR_CTRL)
            ctrl_nxt = reg_wdata[fbs_pkg::CTRL_W-1:0];
         else if (reg_addr == fbs_pkg::ADDR_FULL_THR)
            full_thr_nxt = reg_wdata[TW-1:0];
         else if (reg_addr == fbs_pkg::ADDR_AFULL_THR)
            afull_thr_nxt = reg_wdata[TW-1:0];
         else if (reg_addr == fbs_pkg::ADDR_AEMPTY_THR)
            aempty_thr_nxt = reg_wdata[TW-1:0];
         else if (reg_addr == fbs_pkg::ADDR_INT_STAT)
            int_stat_nxt = int_stat_r & ~reg_wdata[fbs_pkg::EV_N-1:0];
         else if (reg_addr == fbs_pkg::ADDR_INT_MASK)
            int_mask_nxt = reg_wdata[fbs_pkg::EV_N-1:0];
      end
      int_stat_nxt = int_stat_nxt | ev;
   end

   // register read mux, unmapped reads zero
   always_comb
   begin
      reg_rdata_nxt = '0;
      if (reg_rd)
      begin
         if (reg_addr == fbs_pkg::ADDR_CTRL)
            reg_rdata_nxt = 32'(ctrl_r);
         else if (reg_addr == fbs_pkg::ADDR_FULL_THR)
            reg_rdata_nxt = 32'(full_thr_r);
         else if (reg_addr == fbs_pkg::ADDR_AFULL_THR)
            reg_rdata_nxt = 32'(afull_thr_r);
         else if (reg_addr == fbs_pkg::ADDR_AEMPTY_THR)
            reg_rdata_nxt = 32'(aempty_thr_r);
         else if (reg_addr == fbs_pkg::ADDR_STATUS)
         begin
            reg_rdata_nxt[fbs_pkg::ST_FULL] = full_r;
            reg_rdata_nxt[fbs_pkg::ST_AFULL] = afull_r;
            reg_rdata_nxt[fbs_pkg::ST_EMPTY] = empty_r;
            reg_rdata_nxt[fbs_pkg::ST_AEMPTY] = aempty_r;
            reg_rdata_nxt[fbs_pkg::ST_WCOUNT +: 16] = 16'(wcount);
         end
         else if (reg_addr == fbs_pkg::ADDR_INT_STAT)
            reg_rdata_nxt = 32'(int_stat_r);
         else if (reg_addr == fbs_pkg::ADDR_INT_MASK)
            reg_rdata_nxt = 32'(int_mask_r);
      end
   end

   // software register bank
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_r <= fbs_pkg::CTRL_RST;
         full_thr_r <= TW'(DEPTH);
         afull_thr_r <= TW'(DEPTH - fbs_pkg::AFULL_MARGIN);
         aempty_thr_r <= fbs_pkg::AEMPTY_THR_RST;
         int_stat_r <= fbs_pkg::INT_RST;
         int_mask_r <= fbs_pkg::INT_RST;
         reg_rdata_r <= '0;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         full_thr_r <= full_thr_nxt;
         afull_thr_r <= afull_thr_nxt;
         aempty_thr_r <= aempty_thr_nxt;
         int_stat_r <= int_stat_nxt;
         int_mask_r <= int_mask_nxt;
         reg_rdata_r <= reg_rdata_nxt;
      end
   end

   // outputs
   assign rd_data = rd_data_r;
   assign full = full_r;
   assign almost_full = afull_r;
   assign empty = empty_r;
   assign almost_empty = aempty_r;
   assign reg_rdata = reg_rdata_r;
   assign irq = |(int_stat_r & int_mask_r);
endmodule

/* File: tb/fbs_fifo_monitor.sv */
// assertions on the flagged buffer ports, bound from the bench top
// assumes every pin is sampled on clk and rst is async, active high
`timescale 1ns/1ns
module fbs_fifo_monitor #(
   parameter int unsigned DATA_W = 32
)
(
   input wire logic clk, // system clock
   input wire logic rst, // async reset
   input wire logic wr_clk_pin, // fill clock
   input wire logic rd_clk_pin, // drain clock
   input wire logic [3:0] global_clock_nets, // global nets
   input wire logic input_side_enable, // write enable
   input wire logic output_side_enable, // read enable
   input wire logic [DATA_W-1:0] rd_data, // popped word
   input wire logic full, // full flag
   input wire logic almost_full, // almost full flag
   input wire logic empty, // empty flag
   input wire logic almost_empty, // almost empty flag
   input wire logic local_clear, // flag clear
   input wire logic [7:0] reg_addr, // register address
   input wire logic [31:0] reg_wdata, // register write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire logic [31:0] reg_rdata, // register read data
   input wire logic irq // interrupt
);
   logic [15:0] ctl_r, ctl_nxt;
   logic ws_r, ws_nxt, rs_r, rs_nxt, wtick, rtick, clr, cmd_wr;

   function automatic logic pick_clk(input logic [2:0] s, input logic p, input logic [3:0] n);
      return (s == 3'h0 || s > 3'h4) ? p : n[2'(s - 3'h1)]; // spare codes fall to the pin
   endfunction

   function automatic logic pick_ce(input logic [1:0] c, input logic p, input logic [3:0] n);
      return (c == 2'h1) ? n[1] : (c == 2'h2) ? n[2] : p;
   endfunction

   // shadow of the control word and the selected source levels
   always_comb
   begin
      ctl_nxt = ctl_r;
      if (reg_wr && reg_addr == fbs_pkg::ADDR_CTRL)
         ctl_nxt = reg_wdata[15:0];
      ws_nxt = pick_clk(ctl_r[2:0], wr_clk_pin, global_clock_nets) ^ ctl_r[3];
      rs_nxt = pick_clk(ctl_r[9:7], rd_clk_pin, global_clock_nets) ^ ctl_r[10];
      wtick = ws_nxt && !ws_r
         && (pick_ce(ctl_r[5:4], input_side_enable, global_clock_nets) ^ ctl_r[6]);
      rtick = rs_nxt && !rs_r
         && (pick_ce(ctl_r[12:11], output_side_enable, global_clock_nets) ^ ctl_r[13]);
      clr = local_clear ^ ctl_r[15];
      cmd_wr = reg_wr && reg_addr == fbs_pkg::ADDR_CMD && reg_wdata[0];
   end

   // previous source levels start high, as in the design
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctl_r <= 16'h0000;
         ws_r <= 1'b1;
         rs_r <= 1'b1;
      end
      else
      begin
         ctl_r <= ctl_nxt;
         ws_r <= ws_nxt;
         rs_r <= rs_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_reset_state: assert property (disable iff (1'b0) rst |-> !full && !almost_full
      && empty && almost_empty && !irq && reg_rdata == 32'h0 && rd_data == '0)
      else $error("outputs not at reset values");
   a_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("register read data outside its slot");
   a_empty_aempty: assert property (empty |-> almost_empty)
      else $error("empty without almost empty");
   a_wflag_hold: assert property (!wtick && !clr |=> $stable(full) && $stable(almost_full))
      else $error("write flags moved without a write tick");
   a_rflag_hold: assert property (!rtick && !clr && !cmd_wr && !$past(cmd_wr)
      |=> $stable(empty) && $stable(almost_empty))
      else $error("read flags moved without a read tick");
   a_rdata_hold: assert property (!ctl_r[14] && !rtick |=> $stable(rd_data))
      else $error("read data moved without a read tick");
   a_clear_flags: assert property (clr && !wtick |=> !full && !almost_full)
      else $error("local clear left a write flag set");
   a_full_cause: assert property ($rose(full) |-> $past(wtick))
      else $error("full rose without a write tick");
endmodule

/* File: tb/fbs_user.sv */
// fill and drain user logic model facing the buffer data pins
// assumes the buffer samples these levels at the rising clk edge
`timescale 1ns/1ns
module fbs_user #(
   parameter int unsigned W = 8
)
(
   input wire logic clk, // system clock
   output logic wr_clk_pin, // fill clock
   output logic input_side_enable, // write enable
   output logic [W-1:0] wr_data, // word to push
   output logic rd_clk_pin, // drain clock
   output logic output_side_enable // read enable
);
   // idle levels, both clocks stand low between words
   initial
   begin
      wr_clk_pin = 1'b0;
      input_side_enable = 1'b0;
      wr_data = '0;
      rd_clk_pin = 1'b0;
      output_side_enable = 1'b0;
   end

   // one fill pulse per word; pushing past full only when the bench means it
   task automatic push(input logic [W-1:0] d);
      @(posedge clk);
      wr_clk_pin <= 1'b1;
      input_side_enable <= 1'b1;
      wr_data <= d;
      @(posedge clk);
      wr_clk_pin <= 1'b0;
      input_side_enable <= 1'b0;
      wr_data <= ~d; // released data does not keep the word
   endtask

   // one drain pulse per word; popping when empty only when the bench means it
   task automatic pop();
      @(posedge clk);
      rd_clk_pin <= 1'b1;
      output_side_enable <= 1'b1;
      @(posedge clk);
      rd_clk_pin <= 1'b0;
      output_side_enable <= 1'b0;
   endtask
endmodule

/* File: tb/fbs_fifo_tb_top.sv */
// bench top for the flagged buffer: registers, sources, flags, rewind, show-ahead
// assumes fbs_user on the data pins and the monitor bound below
`timescale 1ns/1ns
module fbs_fifo_tb_top;
   localparam int unsigned DW = 8;
   localparam logic [31:0] DEPTH = fbs_pkg::TOTAL_BITS / DW;
   typedef struct packed {logic [7:0] a; logic [31:0] v;} fbs_row_t;
   logic clk, rst, wr_clk_pin, rd_clk_pin, input_side_enable, output_side_enable;
   logic full, almost_full, empty, almost_empty, local_clear, reg_wr, reg_rd, irq;
   logic [3:0] nets;
   logic [3:0] seq [4] = '{4'h2, 4'h3, 4'h2, 4'h0};
   logic [DW-1:0] wr_data, rd_data;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rv;
   int n_mismatch, comparisons;
   fbs_row_t rows [9];

   fbs_user #(.W(DW)) u_user (.clk, .wr_clk_pin, .input_side_enable, .wr_data,
      .rd_clk_pin, .output_side_enable);
   fbs_fifo #(.DATA_W(DW)) dut (.clk, .rst, .wr_clk_pin, .rd_clk_pin,
      .global_clock_nets(nets), .input_side_enable, .output_side_enable, .wr_data,
      .rd_data, .full, .almost_full, .empty, .almost_empty, .local_clear, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);

   // free-running system clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask

   task automatic finish_test();
      if (n_mismatch == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // cut a hang short well past the expected run length
   initial
   begin
      #(5000 * 100);
      n_mismatch++;
      finish_test();
   end

   // main sequence
   initial
   begin
      rst = 1'b0;
      nets = 4'h0;
      local_clear = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      n_mismatch = 0;
      comparisons = 0;
      rows = '{{fbs_pkg::ADDR_CTRL, 32'h0}, {fbs_pkg::ADDR_FULL_THR, DEPTH},
         {fbs_pkg::ADDR_AFULL_THR, DEPTH - 32'h4}, {fbs_pkg::ADDR_AEMPTY_THR, 32'h4},
         {fbs_pkg::ADDR_CMD, 32'h0}, {fbs_pkg::ADDR_STATUS, 32'hc},
         {fbs_pkg::ADDR_INT_STAT, 32'h0}, {fbs_pkg::ADDR_INT_MASK, 32'h0}, {8'h20, 32'h0}};
      #10;
      rst = 1'b1; // clean rising edge so every register is known at the first clk
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i])
      begin
         reg_read(rows[i].a, rv);
         check("register", rows[i].v, rv);
      end
      // write clock from net0, enable from net1, clock plain then inverted
      for (int k = 0; k < 2; k++)
      begin
         reg_write(fbs_pkg::ADDR_CTRL, k ? 32'h19 : 32'h11);
         u_user.push(8'h55);
         foreach (seq[j])
         begin
            @(posedge clk);
            nets <= seq[j];
         end
         repeat (4) @(posedge clk);
         reg_read(fbs_pkg::ADDR_STATUS, rv);
         check("net count", {16'(k + 1), 16'hc}, rv);
      end
      // second reset in mid-run
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      reg_read(fbs_pkg::ADDR_STATUS, rv);
      check("status", 32'hc, rv);
      reg_write(fbs_pkg::ADDR_FULL_THR, 32'h6);
      reg_write(fbs_pkg::ADDR_AFULL_THR, 32'h4);
      reg_write(fbs_pkg::ADDR_AEMPTY_THR, 32'h2);
      reg_write(fbs_pkg::ADDR_INT_MASK, 32'h3f);
      // six words reach the thresholds, a seventh overflows
      for (int i = 0; i < 7; i++)
      begin
         u_user.push(8'ha0 + 8'(i));
         @(negedge clk);
         check("write flags", {30'h0, i >= 5, i >= 3}, {30'h0, full, almost_full});
      end
      check("irq", 32'h1, {31'h0, irq});
      reg_read(fbs_pkg::ADDR_INT_STAT, rv);
      check("events", 32'h13, rv);
      reg_write(fbs_pkg::ADDR_INT_STAT, 32'h13);
      @(posedge clk);
      @(negedge clk);
      check("irq", 32'h0, {31'h0, irq});
      repeat (4) @(posedge clk);
      // six pops in order, then one pop too many
      for (int i = 0; i < 7; i++)
      begin
         u_user.pop();
         @(negedge clk);
         if (i < 6)
            check("rd_data", {24'h0, 8'ha0 + 8'(i)}, {24'h0, rd_data});
         check("read flags", {30'h0, i >= 5, i >= 3}, {30'h0, empty, almost_empty});
      end
      check("full held", 32'h3, {30'h0, full, almost_full});
      @(posedge clk);
      local_clear <= 1'b1;
      @(posedge clk);
      local_clear <= 1'b0;
      @(negedge clk);
      check("cleared", 32'h0, {30'h0, full, almost_full});
      reg_read(fbs_pkg::ADDR_INT_STAT, rv);
      check("events", 32'h2c, rv);
      // rewind replays the frame, then show-ahead shows the next word early
      reg_write(fbs_pkg::ADDR_CMD, 32'h1);
      repeat (4) @(posedge clk);
      u_user.pop();
      @(negedge clk);
      check("rewound", 32'ha0, {24'h0, rd_data});
      check("read flags", 32'h0, {30'h0, empty, almost_empty});
      reg_write(fbs_pkg::ADDR_CTRL, 32'h4000);
      repeat (3) @(posedge clk);
      @(negedge clk);
      check("ahead", 32'ha1, {24'h0, rd_data});
      u_user.pop();
      @(posedge clk);
      @(negedge clk);
      check("ahead", 32'ha2, {24'h0, rd_data});
      // read clock from net0, read enable from net1: one tick pops one word
      reg_write(fbs_pkg::ADDR_CTRL, 32'h880);
      foreach (seq[j])
      begin
         @(posedge clk);
         nets <= seq[j];
      end
      repeat (4) @(posedge clk);
      reg_read(fbs_pkg::ADDR_STATUS, rv);
      check("net read", 32'h00030000, rv);
      // inverted clear polarity holds the flags cleared while the pin is low
      reg_write(fbs_pkg::ADDR_CTRL, 32'h8000);
      @(posedge clk);
      @(negedge clk);
      check("clear inv", 32'h3, {28'h0, full, almost_full, empty, almost_empty});
      finish_test();
   end
endmodule

bind fbs_fifo fbs_fifo_monitor #(.DATA_W(DATA_W)) u_mon (.clk, .rst, .wr_clk_pin, .rd_clk_pin,
   .global_clock_nets, .input_side_enable, .output_side_enable, .rd_data, .full, .almost_full,
   .empty, .almost_empty, .local_clear, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .irq);
